// File: hw/ies_cfg.svh
// constants for the instruction execution subset core
// How it works
// - bit set: next instruction runs normally
// - bit clear: next discarded, nop, two cycles
// - complement to W (d=0) or file (d=1), Z
// - decrement to W or file, only Z
// - clear file writes zero, sets Z
// - clear working loads zero, sets Z
// - call pushes pc plus one first
// - call loads 11-bit target into pc[10:0]
// - call takes pc[12:11] from latch bits 4:3
// - call takes two cycles, flags unchanged
// - clear watchdog zeroes watchdog count
// - clear watchdog zeroes its prescaler
// - clear watchdog sets timeout, powerdown bits
`ifndef IES_CFG_SVH
`define IES_CFG_SVH

`define IES_DW          8
`define IES_PCW         13
`define IES_FADDRW      7
`define IES_ADDRW       8
`define IES_FILE_DEPTH  128
`define IES_STACK_DEPTH 8
`define IES_CY_DIV      4
`define IES_PRE_W       8
`define IES_WDT_W       8

`define IES_A_W         8'h80
`define IES_A_STATUS    8'h81
`define IES_A_LATCH     8'h82
`define IES_A_PCL       8'h83
`define IES_A_PCH       8'h84
`define IES_A_WDT       8'h85
`define IES_A_PRE       8'h86
`define IES_A_TOSL      8'h87
`define IES_A_TOSH      8'h88
`define IES_A_CTRL      8'h89

`define IES_ST_Z        2
`define IES_ST_PD       3
`define IES_ST_TO       4
`define IES_ST_RST      8'h18
`define IES_CTRL_RUN    0
`define IES_CTRL_RST    8'h01
`define IES_LATCH_LO    3
`define IES_LATCH_HI    4

`endif

// File: hw/ies_pkg.sv
// types shared by the execution subset core and its helpers
package ies_pkg;
  typedef enum logic [2:0] {
    IES_OP_NOP,
    IES_OP_BIT_TEST_SKIP_CLEAR,
    IES_OP_CALL,
    IES_OP_COMPLEMENT_FILE,
    IES_OP_CLEAR_FILE,
    IES_OP_CLEAR_WORKING,
    IES_OP_DECREMENT_FILE,
    IES_OP_CLEAR_WATCHDOG
  } ies_op_t;

  typedef enum logic {
    IES_ST_EXEC,
    IES_ST_SLOT
  } ies_state_t;
endpackage

// File: hw/ies_alu.sv
// data path for the file-register instructions: result, destination, zero
`timescale 1ns/100ps
`include "ies_cfg.svh"
module ies_alu
  import ies_pkg::*;
#(
  parameter int DW = `IES_DW
) (
  input  wire ies_op_t       op,
  input  wire logic          dest_f,
  input  wire logic [DW-1:0] fval,
  output logic      [DW-1:0] result,
  output logic               wr_w,
  output logic               wr_f,
  output logic               z_upd,
  output logic               z_val
);
  always_comb begin
    result = '0;
    wr_w   = 1'b0;
    wr_f   = 1'b0;
    z_upd  = 1'b0;
    case (op)
      IES_OP_COMPLEMENT_FILE: begin
        result = ~fval;
        wr_w   = ~dest_f;
        wr_f   = dest_f;
        z_upd  = 1'b1;
      end
      IES_OP_DECREMENT_FILE: begin
        result = fval - DW'(1);
        wr_w   = ~dest_f;
        wr_f   = dest_f;
        z_upd  = 1'b1;
      end
      IES_OP_CLEAR_FILE: begin
        wr_f  = 1'b1;
        z_upd = 1'b1;
      end
      IES_OP_CLEAR_WORKING: begin
        wr_w  = 1'b1;
        z_upd = 1'b1;
      end
      default: ;
    endcase
  end
  // clears give a zero result, so this also sets Z for them
  assign z_val = (result == '0);
endmodule

// File: hw/ies_stack.sv
// hardware return stack, push only in this subset, wraps when full
`timescale 1ns/100ps
`include "ies_cfg.svh"
module ies_stack #(
  parameter int DEPTH = `IES_STACK_DEPTH,
  parameter int AW    = `IES_PCW
) (
  input  wire logic          ref_clk,
  input  wire logic          nrst,
  input  wire logic          push,
  input  wire logic [AW-1:0] push_val,
  output logic      [AW-1:0] top
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [AW-1:0] mem_r [DEPTH];
  logic [PW-1:0] ptr_r;
  logic [PW-1:0] ptr_nxt;

  // overflow silently overwrites the oldest entry, as the core has no trap
  assign ptr_nxt = (ptr_r == PW'(DEPTH - 1)) ? '0 : ptr_r + PW'(1);
  assign top     = mem_r[ptr_r];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ptr_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (push) begin
      ptr_r          <= ptr_nxt;
      mem_r[ptr_nxt] <= push_val;
    end
  end
endmodule

// File: hw/ies_core.sv
// execution core for a subset of the 8-bit instruction set
`timescale 1ns/100ps
`include "ies_cfg.svh"
module ies_core
  import ies_pkg::*;
#(
  parameter int DW       = `IES_DW,
  parameter int PCW      = `IES_PCW,
  parameter int FAW      = `IES_FADDRW,
  parameter int AW       = `IES_ADDRW,
  parameter int FDEPTH   = `IES_FILE_DEPTH,
  parameter int SDEPTH   = `IES_STACK_DEPTH,
  parameter int CY_DIV   = `IES_CY_DIV,
  parameter int PRE_W    = `IES_PRE_W,
  parameter int WDT_W    = `IES_WDT_W
) (
  input  wire logic          ref_clk,
  input  wire logic          nrst,
  // instruction presented for the current instruction cycle
  input  wire logic          instr_valid,
  input  wire ies_op_t       instr_op,
  input  wire logic [FAW-1:0] instr_f,
  input  wire logic [2:0]    instr_b,
  input  wire logic          instr_d,
  input  wire logic [10:0]   instr_k,
  // register port
  input  wire logic [AW-1:0] reg_addr,
  input  wire logic [DW-1:0] reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [DW-1:0] reg_rdata,
  // state seen by the fetch side
  output logic      [PCW-1:0] pc,
  output logic               cycle_en,
  output logic               retire,
  output logic               discard
);

  // ---------------------------------------------------------------
  // instruction cycle divider
  // ---------------------------------------------------------------
  localparam int CW = (CY_DIV > 1) ? $clog2(CY_DIV) : 1;
  logic [CW-1:0] div_r;
  logic          cy_tick;

  assign cy_tick = (div_r == CW'(CY_DIV - 1));

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_r <= '0;
    end else begin
      div_r <= cy_tick ? '0 : div_r + CW'(1);
    end
  end

  // ---------------------------------------------------------------
  // architectural state
  // ---------------------------------------------------------------
  logic [DW-1:0]    file_r [FDEPTH];
  logic [DW-1:0]    w_r;
  logic [DW-1:0]    status_r;
  logic [DW-1:0]    latch_r;
  logic [DW-1:0]    ctrl_r;
  logic [PCW-1:0]   pc_r;
  logic [PRE_W-1:0] pre_r;
  logic [WDT_W-1:0] wdt_r;
  ies_state_t       state_r;
  ies_state_t       state_nxt;
  logic [PCW-1:0]   pc_nxt;
  logic             retire_r;
  logic             discard_r;
  logic             cycle_en_r;
  logic [DW-1:0]    rdata_r;

  // ---------------------------------------------------------------
  // decode of the presented instruction
  // ---------------------------------------------------------------
  wire            running  = ctrl_r[`IES_CTRL_RUN];
  wire            cy_en    = cy_tick && running;
  wire            in_slot  = (state_r == IES_ST_SLOT);
  wire            do_exec  = cy_en && !in_slot && instr_valid;
  wire            do_slot  = cy_en && in_slot;
  wire            is_skip  = (instr_op == IES_OP_BIT_TEST_SKIP_CLEAR);
  wire            is_call  = (instr_op == IES_OP_CALL);
  wire            is_clrwd = (instr_op == IES_OP_CLEAR_WATCHDOG);
  wire [DW-1:0]   fval     = file_r[instr_f];
  wire            tbit     = fval[instr_b];
  wire            skip_hit = is_skip && !tbit;
  wire [PCW-1:0]  pc_inc   = pc_r + PCW'(1);
  wire [PCW-1:0]  call_pc  = {latch_r[`IES_LATCH_HI:`IES_LATCH_LO],
                              instr_k};

  // ---------------------------------------------------------------
  // data path
  // ---------------------------------------------------------------
  logic [DW-1:0] alu_res;
  logic          alu_wr_w;
  logic          alu_wr_f;
  logic          alu_z_upd;
  logic          alu_z_val;

  ies_alu #(
    .DW (DW)
  ) u_alu (
    .op     (instr_op),
    .dest_f (instr_d),
    .fval   (fval),
    .result (alu_res),
    .wr_w   (alu_wr_w),
    .wr_f   (alu_wr_f),
    .z_upd  (alu_z_upd),
    .z_val  (alu_z_val)
  );

  // the alu answers only for one-cycle instructions, so gate on exec
  wire core_wr_w = do_exec && alu_wr_w;
  wire core_wr_f = do_exec && alu_wr_f;
  wire core_z    = do_exec && alu_z_upd;
  wire do_clrwd  = do_exec && is_clrwd;
  wire do_push   = do_exec && is_call;

  // ---------------------------------------------------------------
  // return stack
  // ---------------------------------------------------------------
  logic [PCW-1:0] top_of_return_stack;

  ies_stack #(
    .DEPTH (SDEPTH),
    .AW    (PCW)
  ) u_stack (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .push     (do_push),
    .push_val (pc_inc),
    .top      (top_of_return_stack)
  );

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    pc_nxt    = pc_r;
    case (state_r)
      IES_ST_EXEC: begin
        if (do_exec) begin
          if (is_call) begin
            pc_nxt    = call_pc;
            state_nxt = IES_ST_SLOT;
          end else if (skip_hit) begin
            pc_nxt    = pc_inc;
            state_nxt = IES_ST_SLOT;
          end else begin
            pc_nxt    = pc_inc;
          end
        end
      end
      IES_ST_SLOT: begin
        // the slot runs a nop; after a skip it steps over the
        // discarded word, after a call the target is already loaded
        if (do_slot) begin
          state_nxt = IES_ST_EXEC;
        end
      end
      default: state_nxt = IES_ST_EXEC;
    endcase
  end

  // a skip leaves the pc on the discarded word, the slot steps past it
  logic slot_after_skip_r;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r           <= IES_ST_EXEC;
      slot_after_skip_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (do_exec) begin
        slot_after_skip_r <= skip_hit && !is_call;
      end
    end
  end

  // ---------------------------------------------------------------
  // register port decode
  // ---------------------------------------------------------------
  wire          bus_file  = (reg_addr < AW'(FDEPTH));
  wire [FAW-1:0] bus_fidx = reg_addr[FAW-1:0];
  wire          bw_w      = reg_wr && (reg_addr == `IES_A_W);
  wire          bw_st     = reg_wr && (reg_addr == `IES_A_STATUS);
  wire          bw_latch  = reg_wr && (reg_addr == `IES_A_LATCH);
  wire          bw_pcl    = reg_wr && (reg_addr == `IES_A_PCL);
  wire          bw_pch    = reg_wr && (reg_addr == `IES_A_PCH);
  wire          bw_ctrl   = reg_wr && (reg_addr == `IES_A_CTRL);
  wire          bw_file   = reg_wr && bus_file;

  function automatic logic [DW-1:0] zx_pc(input logic [PCW-1:0] v,
                                          input logic hi);
    logic [2*DW-1:0] t;
    t = {{(2*DW-PCW){1'b0}}, v};
    return hi ? t[2*DW-1:DW] : t[DW-1:0];
  endfunction

  logic [DW-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    if (bus_file) begin
      rd_mux = file_r[bus_fidx];
    end else begin
      case (reg_addr)
        `IES_A_W:      rd_mux = w_r;
        `IES_A_STATUS: rd_mux = status_r;
        `IES_A_LATCH:  rd_mux = latch_r;
        `IES_A_PCL:    rd_mux = zx_pc(pc_r, 1'b0);
        `IES_A_PCH:    rd_mux = zx_pc(pc_r, 1'b1);
        `IES_A_WDT:    rd_mux = DW'(wdt_r);
        `IES_A_PRE:    rd_mux = DW'(pre_r);
        `IES_A_TOSL:   rd_mux = zx_pc(top_of_return_stack, 1'b0);
        `IES_A_TOSH:   rd_mux = zx_pc(top_of_return_stack, 1'b1);
        `IES_A_CTRL:   rd_mux = ctrl_r;
        default:       rd_mux = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= reg_rd ? rd_mux : '0;
    end
  end

  // ---------------------------------------------------------------
  // file registers and working register
  // ---------------------------------------------------------------
  // the core's own write wins over a software write in the same cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < FDEPTH; i++) begin
        file_r[i] <= '0;
      end
    end else if (core_wr_f) begin
      file_r[instr_f] <= alu_res;
    end else if (bw_file) begin
      file_r[bus_fidx] <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      w_r <= '0;
    end else if (core_wr_w) begin
      w_r <= alu_res;
    end else if (bw_w) begin
      w_r <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // status: hardware updates take precedence over software writes
  // ---------------------------------------------------------------
  logic [DW-1:0] status_nxt;

  always_comb begin
    status_nxt = bw_st ? reg_wdata : status_r;
    if (core_z) begin
      status_nxt[`IES_ST_Z] = alu_z_val;
    end
    if (do_clrwd) begin
      status_nxt[`IES_ST_TO] = 1'b1;
      status_nxt[`IES_ST_PD] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      status_r <= `IES_ST_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  // ---------------------------------------------------------------
  // control, latch and program counter
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r  <= `IES_CTRL_RST;
      latch_r <= '0;
    end else begin
      if (bw_ctrl) begin
        ctrl_r <= reg_wdata;
      end
      if (bw_latch) begin
        latch_r <= reg_wdata;
      end
    end
  end

  // software may reposition the pc only while the core is stopped
  wire pc_sw = !running && (bw_pcl || bw_pch);
  wire [2*DW-1:0] pc_wide = {{(2*DW-PCW){1'b0}}, pc_r};
  wire [2*DW-1:0] pc_sw_v = bw_pcl ? {pc_wide[2*DW-1:DW], reg_wdata}
                                   : {reg_wdata, pc_wide[DW-1:0]};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pc_r <= '0;
    end else if (do_slot && slot_after_skip_r) begin
      pc_r <= pc_inc;
    end else if (do_exec) begin
      pc_r <= pc_nxt;
    end else if (pc_sw) begin
      pc_r <= pc_sw_v[PCW-1:0];
    end
  end

  // ---------------------------------------------------------------
  // watchdog count and prescaler
  // ---------------------------------------------------------------
  // the prescaler steps once per instruction cycle; the count steps
  // when it wraps. time-out handling lives outside this core.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pre_r <= '0;
      wdt_r <= '0;
    end else if (do_clrwd) begin
      pre_r <= '0;
      wdt_r <= '0;
    end else if (cy_en) begin
      pre_r <= pre_r + PRE_W'(1);
      if (pre_r == '1) begin
        wdt_r <= wdt_r + WDT_W'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // fetch-side indications
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      retire_r   <= 1'b0;
      discard_r  <= 1'b0;
      cycle_en_r <= 1'b0;
    end else begin
      cycle_en_r <= cy_en;
      retire_r   <= do_exec;
      discard_r  <= do_slot;
    end
  end

  assign pc        = pc_r;
  assign reg_rdata = rdata_r;
  assign retire    = retire_r;
  assign discard   = discard_r;
  assign cycle_en  = cycle_en_r;

endmodule

// File: tb/ies_core_asserts.sv
// concurrent checks on the ports of the execution subset core
`timescale 1ns/100ps
module ies_core_asserts
  import ies_pkg::*;
#(
  parameter int DW     = 8,
  parameter int PCW    = 13,
  parameter int CY_DIV = 4
) (
  input wire logic           ref_clk,
  input wire logic           nrst,
  input wire logic           instr_valid,
  input wire ies_op_t        instr_op,
  input wire logic [10:0]    instr_k,
  input wire logic           reg_wr,
  input wire logic           reg_rd,
  input wire logic [DW-1:0]  reg_rdata,
  input wire logic [PCW-1:0] pc,
  input wire logic           cycle_en,
  input wire logic           retire,
  input wire logic           discard
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // retire is seen one cycle after the tick, so the opcode is one back
  sequence s_done(ies_op_t o);
    retire && $past(instr_op) == o;
  endsequence

  sequence s_one_cyc;
    retire && $past(instr_op) inside {IES_OP_COMPLEMENT_FILE,
      IES_OP_CLEAR_FILE, IES_OP_CLEAR_WORKING, IES_OP_DECREMENT_FILE};
  endsequence

  a_call_slot: assert property (
    s_done(IES_OP_CALL) |-> ##CY_DIV discard)
    else $error("call not followed by a nop slot");
  a_one_cycle: assert property (s_one_cyc |-> ##CY_DIV !discard)
    else $error("single cycle instruction grew a slot");
  a_call_target: assert property (
    s_done(IES_OP_CALL) |-> pc[10:0] == $past(instr_k))
    else $error("call target not in low pc bits");
  a_skip_step: assert property (
    s_done(IES_OP_BIT_TEST_SKIP_CLEAR) |-> pc == $past(pc) + 1'b1)
    else $error("bit test did not advance pc by one");
  a_slot_cause: assert property (discard |-> $past(retire, CY_DIV))
    else $error("nop slot without a preceding execution");
  a_pc_hold: assert property (
    !retire && !discard && !$past(reg_wr) |-> $stable(pc))
    else $error("pc moved with nothing executed");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not zero outside a read");
  a_retire_cause: assert property (retire |-> $past(instr_valid))
    else $error("retire without a valid instruction");
  // both pulses come from one tick, so the tick pulse must stand beside them
  a_tick_pulse: assert property ((retire || discard) |-> cycle_en)
    else $error("execution pulse without an instruction cycle pulse");
endmodule

bind ies_core ies_core_asserts #(.DW(DW), .PCW(PCW), .CY_DIV(CY_DIV)) i_chk (
  .ref_clk(ref_clk), .nrst(nrst), .instr_valid(instr_valid),
  .instr_op(instr_op), .instr_k(instr_k), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pc(pc), .cycle_en(cycle_en), .retire(retire),
  .discard(discard));

// File: tb/ies_core_tb.sv
// self-checking bench for the execution subset core
`timescale 1ns/100ps
module ies_core_tb;
  import ies_pkg::*;
  typedef struct {
    logic [7:0] a;
    logic [7:0] e;
    bit         lim;
  } ies_note_t;
  logic        ref_clk, nrst, instr_valid, instr_d, reg_wr, reg_rd;
  logic        cycle_en, retire, discard;
  logic        rd_q = 1'b0;
  ies_op_t     instr_op, op;
  logic [6:0]  instr_f, f;
  logic [2:0]  instr_b;
  logic [10:0] instr_k;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, v, r, lt;
  logic [12:0] pc, pc_e, top_of_return_stack;
  logic [31:0] seed;
  ies_note_t   notes[$];
  ies_note_t   n;
  int          err_total, tests_run;

  // instruction cycle of one clock keeps the run short
  ies_core #(.CY_DIV(1)) i_dut (
    .ref_clk(ref_clk), .nrst(nrst), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_f(instr_f), .instr_b(instr_b),
    .instr_d(instr_d), .instr_k(instr_k), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pc(pc), .cycle_en(cycle_en),
    .retire(retire), .discard(discard));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] t;
    t = x ^ (x << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // each task leaves one idle edge so no strobe is driven twice per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input bit lim);
    reg_addr <= a;
    reg_rd <= 1'b1;
    notes.push_back('{a, e, lim});
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask

  // two: a clear-working instruction follows, taken only if no slot
  task automatic ex(input ies_op_t o, input logic [6:0] fa,
                    input logic [2:0] b, input logic d,
                    input logic [10:0] k, input bit two);
    instr_op <= o;
    instr_f <= fa;
    instr_b <= b;
    instr_d <= d;
    instr_k <= k;
    instr_valid <= 1'b1;
    @(posedge ref_clk);
    if (two) begin
      instr_op <= IES_OP_CLEAR_WORKING;
      @(posedge ref_clk);
    end
    instr_valid <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic chk_pc;
    rd(8'h83, pc_e[7:0], 0);
    rd(8'h84, {3'h0, pc_e[12:8]}, 0);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rd_q) begin
      n = notes.pop_front();
      tests_run++;
      if (n.lim ? !((reg_rdata <= n.e) === 1'b1) : (reg_rdata !== n.e)) begin
        err_total++;
        $display("BAD reg %h exp %h seen %h", n.a, n.e, reg_rdata);
      end
    end
    rd_q <= reg_rd;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    print_verdict();
  end

  initial begin
    {nrst, instr_valid, instr_d, reg_wr, reg_rd} = 5'h00;
    {instr_f, instr_b, instr_k, reg_addr, reg_wdata} = 37'h0;
    instr_op = IES_OP_NOP;
    err_total = 0;
    tests_run = 0;
    seed = 32'hD388;
    pc_e = 13'h0000;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    rd(8'h81, 8'h18, 0);
    rd(8'h80, 8'h00, 0);
    rd(8'h89, 8'h01, 0);
    rd(8'h8A, 8'h00, 0);
    chk_pc();
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      v = (i == 0) ? 8'hFF : (i == 1) ? 8'h01 : seed[7:0];
      op = i[0] ? IES_OP_DECREMENT_FILE : IES_OP_COMPLEMENT_FILE;
      r = i[0] ? v - 8'h01 : ~v;
      f = seed[14:8];
      wr({1'b0, f}, v);
      wr(8'h80, 8'h5A);
      wr(8'h81, 8'h00);
      ex(op, f, 3'h0, i[1], 11'h000, 0);
      pc_e = pc_e + 13'h0001;
      rd(8'h80, i[1] ? 8'h5A : r, 0);
      rd({1'b0, f}, i[1] ? r : v, 0);
      rd(8'h81, {5'h00, r == 8'h00, 2'h0}, 0);
      chk_pc();
    end
    seed = xs(seed);
    f = seed[6:0];
    wr({1'b0, f}, seed[15:8] | 8'h01);
    wr(8'h81, 8'h00);
    ex(IES_OP_CLEAR_FILE, f, 3'h0, 1'b1, 11'h000, 0);
    rd({1'b0, f}, 8'h00, 0);
    rd(8'h81, 8'h04, 0);
    wr(8'h80, 8'hA5);
    wr(8'h81, 8'h00);
    ex(IES_OP_CLEAR_WORKING, 7'h00, 3'h0, 1'b0, 11'h000, 0);
    pc_e = pc_e + 13'h0002;
    rd(8'h80, 8'h00, 0);
    rd(8'h81, 8'h04, 0);
    chk_pc();
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      v = seed[7:0];
      v[i[2:0]] = i[3];
      f = seed[14:8];
      wr({1'b0, f}, v);
      wr(8'h80, 8'h33);
      wr(8'h81, 8'h00);
      ex(IES_OP_BIT_TEST_SKIP_CLEAR, f, i[2:0], 1'b0, 11'h000, 1);
      pc_e = pc_e + 13'h0002;
      rd(8'h80, i[3] ? 8'h00 : 8'h33, 0);
      rd(8'h81, i[3] ? 8'h04 : 8'h00, 0);
      chk_pc();
    end
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      lt = seed[7:0];
      lt[4:3] = i[1:0];
      wr(8'h82, lt);
      wr(8'h80, 8'h33);
      wr(8'h81, 8'h1C);
      top_of_return_stack = pc_e + 13'h0001;
      ex(IES_OP_CALL, 7'h00, 3'h0, 1'b0, seed[26:16], 1);
      pc_e = {lt[4:3], seed[26:16]};
      rd(8'h87, top_of_return_stack[7:0], 0);
      rd(8'h88, {3'h0, top_of_return_stack[12:8]}, 0);
      chk_pc();
      rd(8'h81, 8'h1C, 0);
      rd(8'h80, 8'h33, 0);
    end
    // a stopped core ignores instructions but lets software move the pc
    wr(8'h89, 8'h00);
    seed = xs(seed);
    pc_e = seed[12:0];
    wr(8'h83, pc_e[7:0]);
    wr(8'h84, {3'h0, pc_e[12:8]});
    ex(IES_OP_NOP, 7'h00, 3'h0, 1'b0, 11'h000, 0);
    chk_pc();
    wr(8'h89, 8'h01);
    ex(IES_OP_NOP, 7'h00, 3'h0, 1'b0, 11'h000, 0);
    pc_e = pc_e + 13'h0001;
    chk_pc();
    wr(8'h85, 8'h55);
    repeat (seed[3:0]) @(posedge ref_clk);
    wr(8'h81, 8'h00);
    ex(IES_OP_CLEAR_WATCHDOG, 7'h00, 3'h0, 1'b0, 11'h000, 0);
    rd(8'h85, 8'h00, 0);
    // the prescaler has stepped on three ticks since the clear
    rd(8'h86, 8'h03, 0);
    rd(8'h81, 8'h18, 0);
    repeat (3) @(posedge ref_clk);
    print_verdict();
  end
endmodule
